/* File: rtl/shift_sign_reg.sv */
// Purpose: Eight-bit shift-right register with sign extend and shared lanes
// Assumes: Mode bits come from a register on the Avalon-MM slave port
// Notes: Serial inputs, lanes and the clear are pins sampled on clk_i
//
// Implementation choices: the address map and the Avalon-MM slave port.
module shift_sign_reg #(
  parameter int WIDTH = 8,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire shift_sign_pkg::avmm_req_t avmm_req_i,
  output shift_sign_pkg::avmm_rsp_t avmm_rsp_o,
  input wire logic serial_in_zero_i,
  input wire logic serial_in_one_i,
  input wire logic async_wipe_n_i,
  input wire logic [WIDTH-1:0] lanes_in_i,
  output shift_sign_pkg::lane_drive_t lanes_drive_o,
  output logic tail_serial_out_o
);

`include "shift_sign_defines.svh"

  // Whole module state
  typedef struct packed {
    logic [WIDTH-1:0] stages;
    shift_sign_pkg::mode_t mode;
    logic [COUNT_WIDTH-1:0] edge_count;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [WIDTH-1:0] stages_next;
  logic stages_changed;
  logic load_sel;
  logic lanes_enabled;

  // Word-aligned address match, shared by reads and writes
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
    addr_hit = (addr[3:2] == offset[3:2]);
  endfunction : addr_hit

  // Read value for one address, zero when unmapped
  function automatic logic [31:0] read_word(input logic [3:0] addr, input state_t s);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr_hit(addr, `SSR_MODE_CTRL_OFFSET)) begin
      word[`SSR_MODE_WIDTH-1:0] = s.mode;
    end else if (addr_hit(addr, `SSR_STAGE_VIEW_OFFSET)) begin
      word[WIDTH-1:0] = s.stages;
      word[`SSR_VIEW_TAIL_BIT] = s.stages[0];
    end else if (addr_hit(addr, `SSR_EDGE_COUNT_OFFSET)) begin
      word[COUNT_WIDTH-1:0] = s.edge_count;
    end
    read_word = word;
  endfunction : read_word

  // Stage update for this edge
  stage_next_logic #(
    .WIDTH(WIDTH)
  ) u_stage_next (
    .stages_i(state_q.stages),
    .mode_i(state_q.mode),
    .serial_in_zero_i(serial_in_zero_i),
    .serial_in_one_i(serial_in_one_i),
    .lanes_i(lanes_in_i),
    .async_wipe_n_i(async_wipe_n_i),
    .next_o(stages_next),
    .changed_o(stages_changed)
  );

  // Next state: stages, bus answer, mode writes, edge counter
  always_comb begin
    state_d = state_q;
    state_d.stages = stages_next;
    if (stages_changed) begin
      state_d.edge_count = state_q.edge_count + 1'b1;
    end
    // One wait cycle, then the answer
    state_d.ack = (avmm_req_i.read || avmm_req_i.write) && !state_q.ack;
    if (avmm_req_i.read && !state_q.ack) begin
      state_d.rdata = read_word(avmm_req_i.address, state_q);
    end
    // Mode write lands on the edge that releases the master
    if (avmm_req_i.write && state_q.ack && avmm_req_i.byteenable[0] &&
        addr_hit(avmm_req_i.address, `SSR_MODE_CTRL_OFFSET)) begin
      state_d.mode = avmm_req_i.writedata[`SSR_MODE_WIDTH-1:0];
    end
    if (reset_i) begin
      state_d.stages = `SSR_STAGE_RESET;
      state_d.mode = `SSR_MODE_CTRL_RESET;
      state_d.edge_count = `SSR_EDGE_COUNT_RESET;
      state_d.ack = 1'b0;
      state_d.rdata = 32'h0000_0000;
    end
  end

  // Register the whole state
  always_ff @(posedge clk_i) begin
    state_q <= state_d;
  end

  // Lane direction: load selects input, pin_drive_n gates the drivers
  assign load_sel = !state_q.mode.word_enable_n && !state_q.mode.serial_not_parallel;
  assign lanes_enabled = !state_q.mode.pin_drive_n && !load_sel;

  // Per-lane drivers, shown low during a clear
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    assign lanes_drive_o.lane_oe[i] = lanes_enabled;
    assign lanes_drive_o.lane_out[i] = state_q.stages[i] && async_wipe_n_i;
  end

  // Tail always driven, forced low by the clear
  assign tail_serial_out_o = state_q.stages[0] && async_wipe_n_i;

  // Bus answer
  assign avmm_rsp_o.waitrequest = (avmm_req_i.read || avmm_req_i.write) && !state_q.ack;
  assign avmm_rsp_o.readdata = state_q.rdata;

endmodule : shift_sign_reg

/* File: rtl/shift_sign_defines.svh */
// Purpose: Constants for the sign-extending shift register block
// Assumes: Byte addresses on the register bus, one 32-bit word per register
// Notes: Definitions only
`ifndef SHIFT_SIGN_DEFINES_SVH
`define SHIFT_SIGN_DEFINES_SVH

// Register byte offsets
`define SSR_MODE_CTRL_OFFSET 4'h0
`define SSR_STAGE_VIEW_OFFSET 4'h4
`define SSR_EDGE_COUNT_OFFSET 4'h8

// Field positions inside the mode control word
`define SSR_WORD_ENABLE_N_BIT 0
`define SSR_SERIAL_NOT_PARALLEL_BIT 1
`define SSR_MSB_REPLICATE_N_BIT 2
`define SSR_SERIAL_IN_CHOICE_BIT 3
`define SSR_PIN_DRIVE_N_BIT 4
`define SSR_MODE_WIDTH 5

// Field positions inside the stage view word
`define SSR_VIEW_TAIL_BIT 8

// Reset values
`define SSR_MODE_CTRL_RESET 5'h17
`define SSR_STAGE_RESET 8'h00
`define SSR_EDGE_COUNT_RESET 16'h0000

`endif

/* File: rtl/shift_sign_pkg.sv */
// Purpose: Types shared by the sign-extending shift register files
// Assumes: Constants come from shift_sign_defines.svh
// Notes: Widths here are plain numbers: 4-bit address, 32-bit data, 8 lanes
package shift_sign_pkg;

  // Mode bits, bit 0 is word_enable_n
  typedef struct packed {
    logic pin_drive_n;
    logic serial_in_choice;
    logic msb_replicate_n;
    logic serial_not_parallel;
    logic word_enable_n;
  } mode_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  // Drive value and enable for each bidirectional lane
  typedef struct packed {
    logic [7:0] lane_out;
    logic [7:0] lane_oe;
  } lane_drive_t;

endpackage : shift_sign_pkg

/* File: rtl/stage_next_logic.sv */
// Purpose: Next value of the eight stages for one clock edge
// Assumes: Stage 7 is msb_stage (lane bit a), stage 0 is the last stage
// Notes: Purely combinational; the caller owns the flip-flops
module stage_next_logic #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] stages_i,
  input wire shift_sign_pkg::mode_t mode_i,
  input wire logic serial_in_zero_i,
  input wire logic serial_in_one_i,
  input wire logic [WIDTH-1:0] lanes_i,
  input wire logic async_wipe_n_i,
  output logic [WIDTH-1:0] next_o,
  output logic changed_o
);

  logic serial_bit;

  // Pick the bit entering msb_stage while shifting
  always_comb begin
    if (!mode_i.msb_replicate_n) begin
      serial_bit = stages_i[WIDTH-1];
    end else if (mode_i.serial_in_choice) begin
      serial_bit = serial_in_one_i;
    end else begin
      serial_bit = serial_in_zero_i;
    end
  end

  // Clear, hold, load or shift right
  always_comb begin
    next_o = stages_i;
    changed_o = 1'b0;
    if (!async_wipe_n_i) begin
      next_o = '0;
    end else if (mode_i.word_enable_n) begin
      next_o = stages_i;
    end else if (!mode_i.serial_not_parallel) begin
      next_o = lanes_i;
      changed_o = 1'b1;
    end else begin
      next_o = {serial_bit, stages_i[WIDTH-1:1]};
      changed_o = 1'b1;
    end
  end

endmodule : stage_next_logic

/* File: verif/shift_sign_sva.sv */
// Purpose: Port checks for shift_sign_reg
// Assumes: Mode bits live in a register, so only port relations are checked
// Notes: Bound from tb_top
module shift_sign_sva #(
  parameter int WIDTH = 8,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire shift_sign_pkg::avmm_req_t avmm_req_i,
  input wire shift_sign_pkg::avmm_rsp_t avmm_rsp_o,
  input wire logic serial_in_zero_i,
  input wire logic serial_in_one_i,
  input wire logic async_wipe_n_i,
  input wire logic [WIDTH-1:0] lanes_in_i,
  input wire shift_sign_pkg::lane_drive_t lanes_drive_o,
  input wire logic tail_serial_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_wipe_tail_low: assert property (!async_wipe_n_i |-> !tail_serial_out_o)
    else $error("tail high during clear");
  a_wipe_lane_low: assert property (!async_wipe_n_i |-> lanes_drive_o.lane_out == 8'h00)
    else $error("lane value high during clear");
  a_oe_all_same: assert property (lanes_drive_o.lane_oe inside {8'h00, 8'hFF})
    else $error("lane enables differ");
  a_tail_on_lane: assert property (lanes_drive_o.lane_oe[0] |->
    lanes_drive_o.lane_out[0] == tail_serial_out_o)
    else $error("tail differs from last lane");
  a_lane_shift_right: assert property (async_wipe_n_i && $past(async_wipe_n_i) &&
    (&lanes_drive_o.lane_oe) && (&$past(lanes_drive_o.lane_oe)) &&
    lanes_drive_o.lane_out != $past(lanes_drive_o.lane_out) |->
    lanes_drive_o.lane_out[6:0] == $past(lanes_drive_o.lane_out[7:1]))
    else $error("lane change is not a right shift");
  a_wait_first: assert property ($rose(avmm_req_i.read || avmm_req_i.write) |->
    avmm_rsp_o.waitrequest) else $error("no wait cycle");
  a_wait_once: assert property ((avmm_req_i.read || avmm_req_i.write) &&
    avmm_rsp_o.waitrequest |=> !avmm_rsp_o.waitrequest) else $error("wait too long");
  a_idle_no_wait: assert property (!(avmm_req_i.read || avmm_req_i.write) |->
    !avmm_rsp_o.waitrequest) else $error("wait while idle");
endmodule : shift_sign_sva

/* File: verif/lane_bus_model.sv */
// Purpose: Parallel bus party on the eight lanes
// Assumes: Drives only while told to
// Notes: An undriven lane shows a level that flips every cycle
module lane_bus_model (
  input wire logic clk_i,
  input wire logic drive_en_i,
  input wire logic [7:0] drive_val_i,
  input wire shift_sign_pkg::lane_drive_t lanes_drive_i,
  output logic [7:0] lanes_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  // Wire level from whichever party drives each lane
  assign lanes_o = (lanes_drive_i.lane_oe & lanes_drive_i.lane_out) |
    (~lanes_drive_i.lane_oe & (drive_en_i ? drive_val_i : ~last_q));
  // Last level, for the floating case
  always_ff @(posedge clk_i) last_q <= lanes_o;
endmodule : lane_bus_model

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for shift_sign_reg
// Assumes: Mode at 0x0, stage view at 0x4, edge count at 0x8
// Notes: Stage contents are checked through the stage view word
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0;
  logic reset_i = 1;
  shift_sign_pkg::avmm_req_t req = '0;
  shift_sign_pkg::avmm_rsp_t rsp;
  shift_sign_pkg::lane_drive_t drv;
  logic d0 = 0;
  logic d1 = 0;
  logic wipe_n = 1;
  logic bus_en = 0;
  logic tail;
  logic [7:0] bus_val = 8'h00;
  logic [7:0] lanes;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] s;
  logic [4:0] m;
  logic b;
  logic oe_exp = 1'b0;
  logic [4:0] modes [3] = '{5'h06, 5'h0E, 5'h02};
  always #50 clk_i = ~clk_i;
  shift_sign_reg shift_sign_reg_i (.clk_i(clk_i), .reset_i(reset_i), .avmm_req_i(req),
    .avmm_rsp_o(rsp), .serial_in_zero_i(d0), .serial_in_one_i(d1), .async_wipe_n_i(wipe_n),
    .lanes_in_i(lanes), .lanes_drive_o(drv), .tail_serial_out_o(tail));
  lane_bus_model lane_bus_model_i (.clk_i(clk_i), .drive_en_i(bus_en), .drive_val_i(bus_val),
    .lanes_drive_i(drv), .lanes_o(lanes));
  task automatic report_and_stop;
    $display("Compared %0d, mismatched %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // One compare, counted, with a BAD line on mismatch
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  // One bus cycle, held until a rising edge sees waitrequest low
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge clk_i);
    req <= '{a, !w, w, d, be};
    do @(posedge clk_i); while (rsp.waitrequest !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0, 4'hF);
  endtask : rd
  // Read answers, and the pins behind a stage view, against the oldest note
  always @(posedge clk_i) begin
    if (req.read && rsp.waitrequest === 1'b0) begin
      check("readdata", rsp.readdata, exp_q[0]);
      if (req.address[3:2] == 2'h1) begin
        check("tail", {31'h0, tail}, {31'h0, exp_q[0][8]});
        check("lane_oe", {24'h0, drv.lane_oe}, {24'h0, {8{oe_exp}}});
        if (oe_exp) check("lane_out", {24'h0, drv.lane_out}, {24'h0, exp_q[0][7:0]});
      end
      void'(exp_q.pop_front());
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    s = 8'($urandom(31));
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(4'h0, 32'h17);
    rd(4'h4, 32'h0);
    rd(4'hC, 32'h0);
    // Load from the bus while the drivers are asked on
    s = 8'($urandom);
    bus_val <= s;
    bus_en <= 1'b1;
    xfer(4'h0, 1'b1, 32'h04, 4'hF);
    xfer(4'h0, 1'b1, 32'h07, 4'hF);
    bus_en <= 1'b0;
    xfer(4'h4, 1'b1, 32'h0, 4'hF);
    xfer(4'h0, 1'b1, 32'h0, 4'h0);
    rd(4'h0, 32'h07);
    oe_exp = 1'b1;
    rd(4'h4, {23'h0, s[0], s});
    // Three shifts per mode, drivers on then off
    for (int i = 0; i < 6; i++) begin
      m = modes[i % 3] | (i > 2 ? 5'h10 : 5'h00);
      b = 1'($urandom);
      d0 <= b;
      d1 <= !b;
      xfer(4'h0, 1'b1, {27'h0, m}, 4'hF);
      xfer(4'h0, 1'b1, 32'h07, 4'hF);
      repeat (3) s = {m[2] ? (m[3] ? !b : b) : s[7], s[7:1]};
      rd(4'h4, {23'h0, s[0], s});
    end
    rd(4'h8, 32'd21);
    // Load selected during a clear
    wipe_n <= 1'b0;
    bus_val <= 8'hFF;
    bus_en <= 1'b1;
    xfer(4'h0, 1'b1, 32'h04, 4'hF);
    xfer(4'h0, 1'b1, 32'h17, 4'hF);
    wipe_n <= 1'b1;
    bus_en <= 1'b0;
    oe_exp = 1'b0;
    rd(4'h4, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
bind shift_sign_reg shift_sign_sva #(.WIDTH(WIDTH), .COUNT_WIDTH(COUNT_WIDTH)) sva_i (
  .clk_i, .reset_i, .avmm_req_i, .avmm_rsp_o, .serial_in_zero_i, .serial_in_one_i,
  .async_wipe_n_i, .lanes_in_i, .lanes_drive_o, .tail_serial_out_o);
